// ==== rtl/faes_pkg.sv ====
// Constants and types for the flash access error status block
// Operation
// (RULE1) Sequencer is command-locked whenever code error, data error or lock flag is 1.
// (RULE2) Software clears both error flags, then issues Status Clear or Forced Stop.
// (RULE3) Status register is an 8-bit unit and resets to 00.
// (RULE4) Error flag clears only by writing 0 after reading 1; writing 1 keeps it.
// (RULE5) Any error flag rising sets the illegal-operation flag and enters lock.
// (RULE6) Code mode: start address 40_0000..FF_FFFF sets code error flag.
// (RULE7) Data mode: start address 1_0000..7_FFFF sets data error flag.
// (RULE8) Data mode config command: address <=0_003F or >=0_0100 sets data error.
// (RULE9) Data mode OTP Set: address <=0_003F or >=0_00A0 sets data error.
// (RULE10) Lock flag reads 1 while locked; set when an error enters the lock.
// (RULE11) Lock flag clears at Status Clear or Forced Stop start with both errors 0.
// (RULE12) Fix flag sets on a 1-bit correction in config, param, OTP or firmware RAM.
// (RULE13) Fix flag clears on Status Clear or Forced Stop when flash fix flags are 1.
// (RULE14) Firmware RAM correction: fix flag clears only on Forced Stop.
// (RULE15) Reserved bits 6,5,2,1 read reset value; software writes reset value.
// (RULE16) Bit 7 code error, bit 4 lock, bit 3 data error, bit 0 fix flag.
// (RULE17) Error interrupt requested when an enabled error or lock flag becomes 1.
// (RULE18) While locked, only Status Clear or Forced Stop are executed.
package faes_pkg;
  localparam logic [31:0] FAES_REG_ADDR = 32'hFFA10010;
  localparam logic [7:0] FAES_RESET_VAL = 8'h00;
  localparam logic [7:0] FAES_RSVD_MASK = 8'h66;
  localparam int FAES_BIT_CODE = 7;
  localparam int FAES_BIT_LOCK = 4;
  localparam int FAES_BIT_DATA = 3;
  localparam int FAES_BIT_FIX = 0;
  localparam logic [23:0] FAES_CODE_RSVD_LO = 24'h400000;
  localparam logic [23:0] FAES_CODE_RSVD_HI = 24'hFFFFFF;
  localparam logic [18:0] FAES_DATA_RSVD_LO = 19'h10000;
  localparam logic [18:0] FAES_DATA_RSVD_HI = 19'h7FFFF;
  localparam logic [18:0] FAES_CFG_LOW_MAX = 19'h0003F;
  localparam logic [18:0] FAES_CFG_HIGH_MIN = 19'h00100;
  localparam logic [18:0] FAES_OTP_HIGH_MIN = 19'h000A0;
  typedef enum logic [1:0] {
    FAES_MODE_READ,
    FAES_MODE_CODE,
    FAES_MODE_DATA
  } faes_mode_t;
  typedef enum logic [2:0] {
    FAES_CMD_OTHER,
    FAES_CMD_CONFIG_SET,
    FAES_CMD_OTP_SET,
    FAES_CMD_STATUS_CLEAR,
    FAES_CMD_FORCED_STOP
  } faes_cmd_t;
endpackage

// ==== rtl/faes_addr_check.sv ====
// Start-address range check for issued sequencer commands
`timescale 1ns/1ps
`default_nettype none
module faes_addr_check
  import faes_pkg::*;
(
  input wire faes_mode_t mode_i,
  input wire faes_cmd_t cmd_i,
  input wire logic [31:0] addr_i,
  output logic code_err_o,
  output logic data_err_o
);
  logic [23:0] code_addr;
  logic [18:0] data_addr;
  assign code_addr = addr_i[23:0];
  assign data_addr = addr_i[18:0];

  always_comb begin
    code_err_o = 1'b0;
    data_err_o = 1'b0;
    if (mode_i == FAES_MODE_CODE) begin
      code_err_o = (code_addr >= FAES_CODE_RSVD_LO) && (code_addr <= FAES_CODE_RSVD_HI); // RULE6
    end
    if (mode_i == FAES_MODE_DATA) begin
      if ((data_addr >= FAES_DATA_RSVD_LO) && (data_addr <= FAES_DATA_RSVD_HI)) begin
        data_err_o = 1'b1; // RULE7
      end
      if (cmd_i == FAES_CMD_CONFIG_SET) begin
        if ((data_addr <= FAES_CFG_LOW_MAX) || (data_addr >= FAES_CFG_HIGH_MIN)) begin
          data_err_o = 1'b1; // RULE8
        end
      end
      if (cmd_i == FAES_CMD_OTP_SET) begin
        if ((data_addr <= FAES_CFG_LOW_MAX) || (data_addr >= FAES_OTP_HIGH_MIN)) begin
          data_err_o = 1'b1; // RULE9
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/faes_status.sv ====
// Access error status register, command lock and error interrupt
`timescale 1ns/1ps
`default_nettype none
module faes_status
  import faes_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] pbus_addr_i,
  input wire logic pbus_sel_i,
  input wire logic pbus_wr_i,
  input wire logic [7:0] pbus_wdata_i,
  output logic [7:0] pbus_rdata_o,
  input wire faes_mode_t mode_i,
  input wire logic cmd_valid_i,
  input wire faes_cmd_t cmd_i,
  input wire logic [31:0] command_start_address_i,
  input wire logic fix_event_i,
  input wire logic config_fix_flag_i,
  input wire logic param_table_fix_flag_i,
  input wire logic onetime_area_fix_flag_i,
  input wire logic firmware_ram_fix_flag_i,
  input wire logic [7:0] access_error_irq_enables_i,
  output logic cmd_exec_o,
  output logic illegal_operation_set_o,
  output logic sequencer_locked_o,
  output logic flash_error_irq_o
);
  logic rst_sync1_ff;
  logic rst_sync2_ff;
  logic rst_b;
  logic code_region_error_flag_ff;
  logic data_region_error_flag_ff;
  logic sequencer_lock_flag_ff;
  logic single_bit_fix_flag_ff;
  logic code_armed_ff;
  logic data_armed_ff;
  logic [7:0] pbus_rdata_ff;
  logic cmd_exec_ff;
  logic illegal_ff;
  logic locked_ff;
  logic irq_ff;
  logic code_hit;
  logic data_hit;
  logic hit;
  logic rd;
  logic wr;
  logic clear_cmd;
  logic locked;
  logic code_set;
  logic data_set;
  logic lock_set;
  logic [7:0] status_word;
  logic [7:0] prev_word_ff;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end
  assign rst_b = rst_sync2_ff;

  faes_addr_check u_addr_check (
    .mode_i(mode_i),
    .cmd_i(cmd_i),
    .addr_i(command_start_address_i),
    .code_err_o(code_hit),
    .data_err_o(data_hit)
  );

  assign hit = pbus_sel_i && (pbus_addr_i == FAES_REG_ADDR);
  assign rd = hit && !pbus_wr_i;
  assign wr = hit && pbus_wr_i;
  // RULE1
  assign locked = code_region_error_flag_ff || data_region_error_flag_ff || sequencer_lock_flag_ff;
  assign clear_cmd = cmd_valid_i && ((cmd_i == FAES_CMD_STATUS_CLEAR) || (cmd_i == FAES_CMD_FORCED_STOP));
  // Commands other than the clearing pair are range checked only when not locked
  assign code_set = cmd_valid_i && !locked && !clear_cmd && code_hit; // RULE18
  assign data_set = cmd_valid_i && !locked && !clear_cmd && data_hit; // RULE18
  assign lock_set = code_set || data_set;

  // Read of 1 arms the zero-write clear of that flag
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      code_armed_ff <= 1'b0;
      data_armed_ff <= 1'b0;
    end else if (rd) begin
      code_armed_ff <= code_region_error_flag_ff; // RULE4
      data_armed_ff <= data_region_error_flag_ff; // RULE4
    end
  end

  // Setting wins over a same-cycle clearing write
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      code_region_error_flag_ff <= 1'b0;
    end else if (code_set) begin
      code_region_error_flag_ff <= 1'b1; // RULE6
    end else if (wr && code_armed_ff && !pbus_wdata_i[FAES_BIT_CODE]) begin
      code_region_error_flag_ff <= 1'b0; // RULE4
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      data_region_error_flag_ff <= 1'b0;
    end else if (data_set) begin
      data_region_error_flag_ff <= 1'b1; // RULE7
    end else if (wr && data_armed_ff && !pbus_wdata_i[FAES_BIT_DATA]) begin
      data_region_error_flag_ff <= 1'b0; // RULE4
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      sequencer_lock_flag_ff <= 1'b0;
    end else if (lock_set) begin
      sequencer_lock_flag_ff <= 1'b1; // RULE10
    end else if (clear_cmd && !code_region_error_flag_ff && !data_region_error_flag_ff) begin
      sequencer_lock_flag_ff <= 1'b0; // RULE11
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      single_bit_fix_flag_ff <= 1'b0;
    end else if (fix_event_i) begin
      single_bit_fix_flag_ff <= 1'b1; // RULE12
    end else if (firmware_ram_fix_flag_i) begin
      if (cmd_valid_i && (cmd_i == FAES_CMD_FORCED_STOP)) begin
        single_bit_fix_flag_ff <= 1'b0; // RULE14
      end
    end else if (clear_cmd && config_fix_flag_i && param_table_fix_flag_i && onetime_area_fix_flag_i) begin
      single_bit_fix_flag_ff <= 1'b0; // RULE13
    end
  end

  // RULE16 RULE15
  always_comb begin
    status_word = FAES_RESET_VAL & FAES_RSVD_MASK;
    status_word[FAES_BIT_CODE] = code_region_error_flag_ff;
    status_word[FAES_BIT_LOCK] = sequencer_lock_flag_ff;
    status_word[FAES_BIT_DATA] = data_region_error_flag_ff;
    status_word[FAES_BIT_FIX] = single_bit_fix_flag_ff;
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      pbus_rdata_ff <= FAES_RESET_VAL; // RULE3
    end else begin
      pbus_rdata_ff <= rd ? status_word : 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      cmd_exec_ff <= 1'b0;
      illegal_ff <= 1'b0;
      locked_ff <= 1'b0;
      irq_ff <= 1'b0;
      prev_word_ff <= FAES_RESET_VAL;
    end else begin
      prev_word_ff <= status_word;
      cmd_exec_ff <= cmd_valid_i && !clear_cmd && !locked && !lock_set; // RULE18
      illegal_ff <= lock_set; // RULE5
      locked_ff <= locked || lock_set; // RULE1
      // Request on a rising enabled flag
      irq_ff <= |(status_word & ~prev_word_ff & access_error_irq_enables_i & ~FAES_RSVD_MASK); // RULE17
    end
  end

  assign pbus_rdata_o = pbus_rdata_ff;
  assign cmd_exec_o = cmd_exec_ff;
  assign illegal_operation_set_o = illegal_ff;
  assign sequencer_locked_o = locked_ff;
  assign flash_error_irq_o = irq_ff;

  // Multi-step reactions to an out-of-range command
  sequence s_error_cmd;
    cmd_valid_i && !locked && !clear_cmd && (code_hit || data_hit);
  endsequence
  sequence s_code_locked;
    code_region_error_flag_ff ##1 sequencer_locked_o;
  endsequence
  sequence s_lock_shown;
    (sequencer_lock_flag_ff && illegal_operation_set_o) ##1 sequencer_locked_o;
  endsequence

  property p_code_set;
    @(posedge clk_i) disable iff (!rst_b) code_set |=> s_code_locked;
  endproperty
  AST_CODE_SET: assert property (p_code_set) else $error("code error did not set and lock"); // RULE6
  AST_ERR_LOCK: assert property (@(posedge clk_i) disable iff (!rst_b) s_error_cmd |=> s_lock_shown) // RULE10
    else $error("error command did not lock");
  AST_DATA_SET: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE7
    data_set |=> data_region_error_flag_ff && sequencer_lock_flag_ff) else $error("data error not set");
  AST_ILLEGAL: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE5
    $rose(illegal_operation_set_o) |-> $past(lock_set)) else $error("illegal flag without error");
  AST_LOCK_OUT: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE1
    locked |=> sequencer_locked_o) else $error("lock not shown");
  AST_NO_EXEC: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE18
    locked |=> !cmd_exec_o) else $error("command ran while locked");
  AST_ONE_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE4
    (wr && !code_set && code_region_error_flag_ff && pbus_wdata_i[FAES_BIT_CODE]) |=> code_region_error_flag_ff)
    else $error("writing 1 changed flag");
  AST_LOCK_CLR: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE11
    (clear_cmd && !lock_set && !code_region_error_flag_ff && !data_region_error_flag_ff) |=> !sequencer_lock_flag_ff)
    else $error("lock not released");
  AST_RSVD: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE15
    rd |=> (pbus_rdata_o & FAES_RSVD_MASK) == 8'h00) else $error("reserved bits nonzero");
  AST_FIX: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE12
    fix_event_i |=> single_bit_fix_flag_ff) else $error("fix flag not set");
  AST_FIX_CLR: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE13
    (clear_cmd && !fix_event_i && !firmware_ram_fix_flag_i && config_fix_flag_i && param_table_fix_flag_i
      && onetime_area_fix_flag_i) |=> !single_bit_fix_flag_ff) else $error("fix flag not cleared");
  AST_FIX_FW: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE14
    (single_bit_fix_flag_ff && firmware_ram_fix_flag_i && !(cmd_valid_i && (cmd_i == FAES_CMD_FORCED_STOP)))
      |=> single_bit_fix_flag_ff) else $error("fix flag left without forced stop");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE17
    ($rose(sequencer_lock_flag_ff) && access_error_irq_enables_i[FAES_BIT_LOCK]) |=> flash_error_irq_o)
    else $error("lock rise without interrupt");
  AST_RD_IDLE: assert property (@(posedge clk_i) disable iff (!rst_b) // RULE3
    !rd |=> (pbus_rdata_o == 8'h00)) else $error("read data without a read");
endmodule
`default_nettype wire

// ==== tb/faes_status_tb.sv ====
// Self-checking testbench for the flash access error status block
`timescale 1ns/1ps
`default_nettype none
module faes_status_tb;
  import faes_pkg::*;
  logic clk_i, rst_b_i, sel, wr, cv, fix, cfg_f, tbl_f, otp_f, fw_f;
  logic [31:0] addr, sa;
  logic [7:0] wd, rd_v, ien, rdata;
  faes_mode_t mode;
  faes_cmd_t cmd;
  logic exec, ill, lck, irq;
  int n_mismatch, comparisons, n_ex, n_il, n_irq;
  faes_status dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .pbus_addr_i(addr), .pbus_sel_i(sel),
    .pbus_wr_i(wr), .pbus_wdata_i(wd), .pbus_rdata_o(rdata), .mode_i(mode), .cmd_valid_i(cv),
    .cmd_i(cmd), .command_start_address_i(sa), .fix_event_i(fix), .config_fix_flag_i(cfg_f),
    .param_table_fix_flag_i(tbl_f), .onetime_area_fix_flag_i(otp_f), .firmware_ram_fix_flag_i(fw_f),
    .access_error_irq_enables_i(ien), .cmd_exec_o(exec), .illegal_operation_set_o(ill),
    .sequencer_locked_o(lck), .flash_error_irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Pulse counters, sampled mid-cycle where outputs are settled
  always @(negedge clk_i) begin
    if (exec === 1'b1) n_ex++;
    if (ill === 1'b1) n_il++;
    if (irq === 1'b1) n_irq++;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sel <= 1'b1;
    wr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk_i);
    sel <= 1'b0;
    wr <= 1'b0;
    #1 rd_v = rdata;
  endtask
  task automatic rdchk(input logic [7:0] e);
    bus(1'b0, FAES_REG_ADDR, 8'h00);
    chk(rd_v, e);
  endtask
  task automatic issue(input faes_mode_t m, input faes_cmd_t c, input logic [31:0] a);
    n_ex = 0;
    n_il = 0;
    n_irq = 0;
    @(posedge clk_i);
    mode <= m;
    cmd <= c;
    sa <= a;
    cv <= 1'b1;
    @(posedge clk_i);
    cv <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic recover(input faes_cmd_t c);
    bus(1'b0, FAES_REG_ADDR, 8'h00);
    bus(1'b1, FAES_REG_ADDR, 8'h00);
    issue(mode, c, 32'h0);
    rdchk(8'h00);
    chk({7'h00, lck}, 8'h00);
  endtask
  task automatic probe(input faes_mode_t m, input faes_cmd_t c, input logic [31:0] a, input logic [7:0] e);
    issue(m, c, a);
    chk({7'h00, n_irq != 0}, {7'h00, e != 8'h00});
    if (e == 8'h00) begin
      chk(8'(n_ex), 8'h01);
    end else begin
      chk(8'(n_il), 8'h01);
      chk({7'h00, lck}, 8'h01);
    end
    rdchk(e);
    if (e != 8'h00) recover(FAES_CMD_STATUS_CLEAR);
  endtask
  task automatic pulse_fix;
    @(posedge clk_i);
    fix <= 1'b1;
    @(posedge clk_i);
    fix <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    finish_test;
  end
  initial begin
    {sel, wr, cv, fix, cfg_f, tbl_f, otp_f, fw_f} = '0;
    {addr, sa, wd} = '0;
    ien = 8'h99;
    mode = FAES_MODE_READ;
    cmd = FAES_CMD_OTHER;
    rst_b_i = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdchk(FAES_RESET_VAL);
    bus(1'b0, FAES_REG_ADDR + 32'h4, 8'h00);
    chk(rd_v, 8'h00);
    probe(FAES_MODE_CODE, FAES_CMD_OTHER, 32'h003FFFFF, 8'h00);
    probe(FAES_MODE_CODE, FAES_CMD_OTHER, 32'h00400000, 8'h90);
    probe(FAES_MODE_CODE, FAES_CMD_OTHER, 32'h00FFFFFF, 8'h90);
    probe(FAES_MODE_CODE, FAES_CMD_OTHER, 32'h01000000, 8'h00);
    probe(FAES_MODE_READ, FAES_CMD_OTHER, 32'h00400000, 8'h00);
    probe(FAES_MODE_DATA, FAES_CMD_OTHER, 32'h0000FFFF, 8'h00);
    probe(FAES_MODE_DATA, FAES_CMD_OTHER, 32'h00010000, 8'h18);
    probe(FAES_MODE_DATA, FAES_CMD_OTHER, 32'h0007FFFF, 8'h18);
    probe(FAES_MODE_DATA, FAES_CMD_OTHER, 32'h00080000, 8'h00);
    probe(FAES_MODE_DATA, FAES_CMD_CONFIG_SET, 32'h3F, 8'h18);
    probe(FAES_MODE_DATA, FAES_CMD_CONFIG_SET, 32'h40, 8'h00);
    probe(FAES_MODE_DATA, FAES_CMD_CONFIG_SET, 32'hFF, 8'h00);
    probe(FAES_MODE_DATA, FAES_CMD_CONFIG_SET, 32'h100, 8'h18);
    probe(FAES_MODE_DATA, FAES_CMD_OTP_SET, 32'h3F, 8'h18);
    probe(FAES_MODE_DATA, FAES_CMD_OTP_SET, 32'h40, 8'h00);
    probe(FAES_MODE_DATA, FAES_CMD_OTP_SET, 32'h9F, 8'h00);
    probe(FAES_MODE_DATA, FAES_CMD_OTP_SET, 32'hA0, 8'h18);
    // Zero write without a prior read of 1 must not clear
    issue(FAES_MODE_CODE, FAES_CMD_OTHER, 32'h00400000);
    bus(1'b1, FAES_REG_ADDR, 8'h00);
    issue(FAES_MODE_CODE, FAES_CMD_OTHER, 32'h0);
    chk(8'(n_ex), 8'h00);
    rdchk(8'h90);
    bus(1'b1, FAES_REG_ADDR, 8'h99);
    rdchk(8'h90);
    bus(1'b1, FAES_REG_ADDR, 8'h00);
    rdchk(8'h10);
    chk({7'h00, lck}, 8'h01);
    issue(FAES_MODE_CODE, FAES_CMD_STATUS_CLEAR, 32'h0);
    rdchk(8'h00);
    // Clear command with an error still set keeps the lock
    issue(FAES_MODE_DATA, FAES_CMD_OTHER, 32'h00010000);
    rdchk(8'h18);
    issue(FAES_MODE_DATA, FAES_CMD_STATUS_CLEAR, 32'h0);
    rdchk(8'h18);
    recover(FAES_CMD_FORCED_STOP);
    ien <= 8'h00;
    issue(FAES_MODE_CODE, FAES_CMD_OTHER, 32'h00400000);
    chk(8'(n_irq), 8'h00);
    recover(FAES_CMD_STATUS_CLEAR);
    ien <= 8'h99;
    pulse_fix;
    rdchk(8'h01);
    chk({7'h00, lck}, 8'h00);
    cfg_f <= 1'b1;
    issue(FAES_MODE_READ, FAES_CMD_STATUS_CLEAR, 32'h0);
    rdchk(8'h01);
    {tbl_f, otp_f} <= 2'b11;
    issue(FAES_MODE_READ, FAES_CMD_STATUS_CLEAR, 32'h0);
    rdchk(8'h00);
    fw_f <= 1'b1;
    pulse_fix;
    issue(FAES_MODE_READ, FAES_CMD_STATUS_CLEAR, 32'h0);
    rdchk(8'h01);
    issue(FAES_MODE_READ, FAES_CMD_FORCED_STOP, 32'h0);
    rdchk(8'h00);
    // Reset in mid-run with an error pending returns the register to its reset value
    issue(FAES_MODE_CODE, FAES_CMD_OTHER, 32'h00400000);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rdchk(FAES_RESET_VAL);
    chk({7'h00, lck}, 8'h00);
    finish_test;
  end
endmodule
`default_nettype wire
